//--- hw/cmx_channel_regs.sv
// Summary of operation
// - Positive selector decodes pin 4, sensor, supply monitor and reference codes.
// - Bits 4:0 pick negative input, same codes, reset to pin 1.
// - Channels 1 to 3 sit at indices 11h-13h, reset 0001h.
// - All four channel registers share one field layout.
// - Bit 15 enables channel; channel 0 resets on; enabled channels are cycled.
// - Bits 13:12 choose one of four setups.
// - Bits 9:5 pick positive input, reset pin 0, codes 0-4 pins.
`timescale 1ns/10ps
`default_nettype none
`include "cmx_regs.svh"

module cmx_channel_regs #(
    parameter int NUM_CH   = 4,
    parameter int DWELL_CY = 16
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [9:0]    s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [9:0]    s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    output logic [3:0]         channel_active_bit,
    output logic [7:0]         setup_choice,
    output logic [19:0]        positive_input_select,
    output logic [19:0]        negative_input_select,
    output logic [1:0]         conv_channel,
    output logic [1:0]         conv_setup,
    output logic [4:0]         conv_pos_sel,
    output logic [4:0]         conv_neg_sel,
    output logic [3:0]         conv_pos_src,
    output logic [3:0]         conv_neg_src,
    output logic               conv_valid
);

    typedef struct packed {
        logic        aw_got;
        logic [7:0]  aw_idx;
        logic        w_got;
        logic [15:0] w_data;
        logic [15:0] w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rpend;
        logic        rvalid;
        logic [1:0]  rresp;
        logic        rhit;
        logic [1:0]  cur;
        logic [15:0] dwell;
        logic        cvalid;
        logic [1:0]  csetup;
        logic [4:0]  cpos;
        logic [4:0]  cneg;
        logic [3:0]  cpsrc;
        logic [3:0]  cnsrc;
        logic [3:0]  en;
        logic [7:0]  setup;
        logic [19:0] pos;
        logic [19:0] neg;
        logic        awrdy;
        logic        wrdy;
        logic        arrdy;
        logic [31:0] rdata;
    } cmx_top_s;

    cmx_top_s st_q;
    cmx_top_s st_d;

    logic        mem_wr;
    logic [1:0]  mem_rd_idx;
    logic [15:0] mem_rd_data;
    logic [NUM_CH*16-1:0] mem_all;

    // Map a register index onto a channel slot
    function automatic logic idx_hit(input logic [7:0] idx);
        return idx >= `CMX_IDX_CH0 && idx <= `CMX_IDX_CH3;
    endfunction

    function automatic logic [1:0] idx_slot(input logic [7:0] idx);
        return 2'(idx - `CMX_IDX_CH0);
    endfunction

    function automatic logic [15:0] strb16(input logic [3:0] s);
        return {{8{s[1]}}, {8{s[0]}}};
    endfunction

    // Reset image of one channel register, as the memory holds it
    function automatic logic [15:0] rst_word(input int i);
        return (i == 0) ? `CMX_RST_CH0 : `CMX_RST_CHN;
    endfunction

    function automatic logic en_of(input logic [15:0] w);
        return w[`CMX_EN_BIT];
    endfunction

    function automatic logic [1:0] setup_of(input logic [15:0] w);
        return w[`CMX_SETUP_HI:`CMX_SETUP_LO];
    endfunction

    function automatic logic [4:0] pos_of(input logic [15:0] w);
        return w[`CMX_POS_HI:`CMX_POS_LO];
    endfunction

    function automatic logic [4:0] neg_of(input logic [15:0] w);
        return w[`CMX_NEG_HI:`CMX_NEG_LO];
    endfunction

    // Classify a selector code for the analog routing
    function automatic cmx_pkg::cmx_src_e src_of(input logic [4:0] c);
        cmx_pkg::cmx_src_e r;
        r = cmx_pkg::CMX_SRC_PIN;
        if (c == `CMX_SEL_TEMP_P || c == `CMX_SEL_TEMP_N)
            r = cmx_pkg::CMX_SRC_TEMP;
        else if (c == `CMX_SEL_SUP_P || c == `CMX_SEL_SUP_N)
            r = cmx_pkg::CMX_SRC_SUPPLY;
        else if (c == `CMX_SEL_REF_P || c == `CMX_SEL_REF_N)
            r = cmx_pkg::CMX_SRC_REF;
        return r;
    endfunction

    // Next enabled channel after cur, wrapping; stays if none else enabled
    function automatic logic [1:0] next_en(input logic [1:0] cur, input logic [3:0] en);
        logic [1:0] r;
        logic [1:0] k;
        r = cur;
        for (int i = 3; i >= 1; i--)
        begin
            k = 2'(cur + 2'(i));
            if (en[k])
                r = k;
        end
        return r;
    endfunction

    always_comb
    begin
        logic [15:0] w;
        logic [1:0]  nx;
        w  = 16'h0000;
        nx = 2'h0;
        st_d   = st_q;
        mem_wr = 1'b0;
        mem_rd_idx = idx_slot(8'(s_axi_araddr[9:2]));

        // Write path: address and data in either order
        if (s_axi_awvalid && st_q.awrdy)
        begin
            st_d.aw_got = 1'b1;
            st_d.aw_idx = s_axi_awaddr[9:2];
        end
        if (s_axi_wvalid && st_q.wrdy)
        begin
            st_d.w_got  = 1'b1;
            st_d.w_data = s_axi_wdata[15:0];
            st_d.w_strb = strb16(s_axi_wstrb);
        end
        if (st_q.aw_got && st_q.w_got)
        begin
            mem_wr = idx_hit(st_q.aw_idx);
            st_d.aw_got = 1'b0;
            st_d.w_got  = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp  = idx_hit(st_q.aw_idx) ? `CMX_RESP_OKAY : `CMX_RESP_SLVERR;
        end
        if (st_q.bvalid && s_axi_bready)
            st_d.bvalid = 1'b0;

        // Read path: memory output is registered, so answer a cycle later
        if (s_axi_arvalid && st_q.arrdy)
        begin
            st_d.rpend = 1'b1;
            st_d.rhit  = idx_hit(s_axi_araddr[9:2]);
        end
        if (st_q.rpend)
        begin
            st_d.rpend  = 1'b0;
            st_d.rvalid = 1'b1;
            st_d.rresp  = st_q.rhit ? `CMX_RESP_OKAY : `CMX_RESP_SLVERR;
            // Captured here: the master may move araddr once the address is taken
            st_d.rdata  = st_q.rhit ? {16'h0000, mem_rd_data} : 32'h0000_0000;
        end
        if (st_q.rvalid && s_axi_rready)
        begin
            st_d.rvalid = 1'b0;
            st_d.rdata  = 32'h0000_0000;
        end

        // Readies from the next state, so each bus output leaves a flip-flop
        st_d.awrdy = !st_d.aw_got && !st_d.bvalid;
        st_d.wrdy  = !st_d.w_got && !st_d.bvalid;
        st_d.arrdy = !st_d.rpend && !st_d.rvalid;

        // Field split, same layout on every channel
        for (int i = 0; i < NUM_CH; i++)
        begin
            w = mem_all[i*16 +: 16];
            st_d.en[i]           = en_of(w);
            st_d.setup[i*2 +: 2] = setup_of(w);
            st_d.pos[i*5 +: 5]   = pos_of(w);
            st_d.neg[i*5 +: 5]   = neg_of(w);
        end

        // Channel sequencer: dwell on one channel, then step to next enabled
        st_d.cvalid = |st_q.en;
        if (!st_q.en[st_q.cur])
        begin
            // Channel switched off mid-dwell is left at once
            st_d.cur   = next_en(st_q.cur, st_q.en);
            st_d.dwell = 16'h0000;
        end
        else if (st_q.dwell == 16'(DWELL_CY - 1))
        begin
            nx = next_en(st_q.cur, st_q.en);
            st_d.cur   = nx;
            st_d.dwell = 16'h0000;
        end
        else
        begin
            st_d.dwell = 16'(st_q.dwell + 16'h0001);
        end
        st_d.csetup = st_q.setup[st_q.cur*2 +: 2];
        st_d.cpos   = st_q.pos[st_q.cur*5 +: 5];
        st_d.cneg   = st_q.neg[st_q.cur*5 +: 5];
        st_d.cpsrc  = src_of(st_q.pos[st_q.cur*5 +: 5]);
        st_d.cnsrc  = src_of(st_q.neg[st_q.cur*5 +: 5]);
    end

    cmx_chan_mem #(
        .NUM_CH (NUM_CH)
    ) u_mem (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (mem_wr),
        .wr_idx  (idx_slot(st_q.aw_idx)),
        .wr_data (st_q.w_data),
        .wr_strb (st_q.w_strb),
        .rd_idx  (mem_rd_idx),
        .rd_data (mem_rd_data),
        .all_q   (mem_all)
    );

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q <= '0;
            // Same image as the memory, so field outputs agree from the first edge
            for (int i = 0; i < NUM_CH; i++)
            begin
                st_q.en[i]           <= en_of(rst_word(i));
                st_q.setup[i*2 +: 2] <= setup_of(rst_word(i));
                st_q.pos[i*5 +: 5]   <= pos_of(rst_word(i));
                st_q.neg[i*5 +: 5]   <= neg_of(rst_word(i));
            end
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign s_axi_awready = st_q.awrdy;
    assign s_axi_wready  = st_q.wrdy;
    assign s_axi_bvalid  = st_q.bvalid;
    assign s_axi_bresp   = st_q.bresp;
    assign s_axi_arready = st_q.arrdy;
    assign s_axi_rvalid  = st_q.rvalid;
    assign s_axi_rresp   = st_q.rresp;
    assign s_axi_rdata   = st_q.rdata;

    assign channel_active_bit    = st_q.en;
    assign setup_choice          = st_q.setup;
    assign positive_input_select = st_q.pos;
    assign negative_input_select = st_q.neg;
    assign conv_channel = st_q.cur;
    assign conv_setup   = st_q.csetup;
    assign conv_pos_sel = st_q.cpos;
    assign conv_neg_sel = st_q.cneg;
    assign conv_pos_src = st_q.cpsrc;
    assign conv_neg_src = st_q.cnsrc;
    assign conv_valid   = st_q.cvalid;

endmodule

`default_nettype wire

//--- pkg/cmx_regs.svh
`ifndef CMX_REGS_SVH
`define CMX_REGS_SVH

// Register indices; byte address is four times the index
`define CMX_IDX_CH0        8'h10
`define CMX_IDX_CH1        8'h11
`define CMX_IDX_CH2        8'h12
`define CMX_IDX_CH3        8'h13

// Field positions
`define CMX_EN_BIT         15
`define CMX_SETUP_HI       13
`define CMX_SETUP_LO       12
`define CMX_POS_HI         9
`define CMX_POS_LO         5
`define CMX_NEG_HI         4
`define CMX_NEG_LO         0

// Writable bits; 14 and 11:10 hold zero
`define CMX_WR_MASK        16'hB3FF

// Reset values
`define CMX_RST_CH0        16'h8001
`define CMX_RST_CHN        16'h0001

// Input selector codes
`define CMX_SEL_PIN0       5'h00
`define CMX_SEL_PIN4       5'h04
`define CMX_SEL_TEMP_P     5'h11
`define CMX_SEL_TEMP_N     5'h12
`define CMX_SEL_SUP_P      5'h13
`define CMX_SEL_SUP_N      5'h14
`define CMX_SEL_REF_P      5'h15
`define CMX_SEL_REF_N      5'h16

// AXI response codes
`define CMX_RESP_OKAY      2'h0
`define CMX_RESP_SLVERR    2'h2

`endif

//--- pkg/cmx_pkg.sv
package cmx_pkg;

    typedef enum logic [3:0] {
        CMX_SRC_PIN     = 4'h1,
        CMX_SRC_TEMP    = 4'h2,
        CMX_SRC_SUPPLY  = 4'h4,
        CMX_SRC_REF     = 4'h8
    } cmx_src_e;

    typedef logic [15:0] cmx_word_t;

endpackage

//--- hw/cmx_chan_mem.sv
`timescale 1ns/10ps
`default_nettype none
`include "cmx_regs.svh"

module cmx_chan_mem #(
    parameter int NUM_CH = 4
) (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic                       wr_en,
    input  wire logic [1:0]                 wr_idx,
    input  wire logic [15:0]                wr_data,
    input  wire logic [15:0]                wr_strb,
    input  wire logic [1:0]                 rd_idx,
    output logic      [15:0]                rd_data,
    output logic      [NUM_CH*16-1:0]       all_q
);

    typedef struct packed {
        logic [NUM_CH*16-1:0] regs;
        logic [15:0]          rd;
    } cmx_mem_s;

    cmx_mem_s st_q;
    cmx_mem_s st_d;

    always_comb
    begin
        st_d = st_q;
        if (wr_en)
        begin
            // Reserved bits never store
            st_d.regs[wr_idx*16 +: 16] = (st_q.regs[wr_idx*16 +: 16] & ~wr_strb)
                | (wr_data & wr_strb & `CMX_WR_MASK);
        end
        st_d.rd = st_q.regs[rd_idx*16 +: 16];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q.rd <= 16'h0000;
            for (int i = 0; i < NUM_CH; i++)
            begin
                st_q.regs[i*16 +: 16] <= (i == 0) ? `CMX_RST_CH0 : `CMX_RST_CHN;
            end
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign rd_data = st_q.rd;
    assign all_q   = st_q.regs;

endmodule

`default_nettype wire

//--- test/cmx_channel_regs_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "cmx_regs.svh"
module cmx_channel_regs_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [9:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        conv_valid,
    input wire logic [4:0]  conv_pos_sel,
    input wire logic [4:0]  conv_neg_sel,
    input wire logic [3:0]  conv_pos_src,
    input wire logic [3:0]  conv_neg_src
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Undefined codes fall back to pin routing
    function automatic logic [3:0] src(input logic [4:0] s);
        if (s == `CMX_SEL_TEMP_P || s == `CMX_SEL_TEMP_N)
            return 4'h2;
        if (s == `CMX_SEL_SUP_P || s == `CMX_SEL_SUP_N)
            return 4'h4;
        if (s == `CMX_SEL_REF_P || s == `CMX_SEL_REF_N)
            return 4'h8;
        return 4'h1;
    endfunction

    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    property p_rsv; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0 && s_axi_rdata[14] == 1'b0
        && s_axi_rdata[11:10] == 2'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
    property p_wblock; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_wblock: assert property (p_wblock) else $error("write taken while answering");
    property p_rblock; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_rblock: assert property (p_rblock) else $error("read taken while answering");
    property p_wresp; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid; endproperty
    a_wresp: assert property (p_wresp) else $error("write answer late");
    property p_rbad; s_axi_arvalid && s_axi_arready && !(s_axi_araddr[9:2] inside {[8'h10:8'h13]})
        |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == `CMX_RESP_SLVERR && s_axi_rdata == 32'h0);
    endproperty
    a_rbad: assert property (p_rbad) else $error("unmapped read not refused");
    property p_rok; s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] inside {[8'h10:8'h13]}
        |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == `CMX_RESP_OKAY); endproperty
    a_rok: assert property (p_rok) else $error("mapped read not answered");
    property p_psrc; conv_valid |-> conv_pos_src == src(conv_pos_sel); endproperty
    a_psrc: assert property (p_psrc) else $error("positive source wrong");
    property p_nsrc; conv_valid |-> conv_neg_src == src(conv_neg_sel); endproperty
    a_nsrc: assert property (p_nsrc) else $error("negative source wrong");
endmodule

bind cmx_channel_regs cmx_channel_regs_monitor u_mon (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .conv_valid    (conv_valid),
    .conv_pos_sel  (conv_pos_sel),
    .conv_neg_sel  (conv_neg_sel),
    .conv_pos_src  (conv_pos_src),
    .conv_neg_src  (conv_neg_src)
);
`default_nettype wire

//--- test/tb_cmx_channel_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "cmx_regs.svh"
module tb_cmx_channel_regs;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [9:0]  awaddr = '0;
    logic        awvalid = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0]  wstrb = '0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic [9:0]  araddr = '0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, cval;
    logic [1:0]  bresp, rresp, cch;
    logic [31:0] rdata;
    logic [3:0]  act;
    logic [7:0]  setup;
    logic [19:0] pos, neg;
    logic [1:0]  csu;
    logic [4:0]  cps, cns;
    logic [3:0]  cpr, cnr;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    // Only documented selector codes
    logic [4:0]  pc [4] = '{5'h04, 5'h11, 5'h13, 5'h15};
    logic [4:0]  nc [4] = '{5'h12, 5'h14, 5'h16, 5'h03};

    cmx_channel_regs #(.NUM_CH(4), .DWELL_CY(2)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .channel_active_bit(act), .setup_choice(setup), .positive_input_select(pos),
        .negative_input_select(neg), .conv_channel(cch), .conv_setup(csu), .conv_pos_sel(cps),
        .conv_neg_sel(cns), .conv_pos_src(cpr), .conv_neg_src(cnr), .conv_valid(cval));

    initial
    begin
        forever #2 aclk = ~aclk;
    end

    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            miscompares++;
            summarize();
        end
    end

    function automatic logic [9:0] ad(input int i);
        return 10'(10'h040 + 4 * i);
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [15:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        logic ap;
        logic wp;
        ap = 1'b1;
        wp = 1'b1;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {16'h0, d};
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (ap || wp)
        begin
            @(posedge aclk);
            if (ap && awready)
            begin
                awvalid <= 1'b0;
                ap = 1'b0;
            end
            if (wp && wready)
            begin
                wvalid <= 1'b0;
                wp = 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rc(input logic [9:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        rready <= 1'b0;
        chk(rdata, e);
        chk(rresp, er);
    endtask

    task automatic t_reset();
        rc(ad(0), {16'h0, `CMX_RST_CH0}, `CMX_RESP_OKAY);
        for (int i = 1; i < 4; i++)
            rc(ad(i), 32'h1, `CMX_RESP_OKAY);
        chk({act, cch}, 6'h04);
        chk(neg, 20'h08421);
        chk({pos, setup}, 28'h0);
        chk({csu, cps, cns, cpr, cnr}, 20'h00111);
        $display("reset test done");
    endtask

    task automatic t_layout();
        logic [1:0]  r;
        logic [15:0] v;
        wr(ad(0), 16'h3000, 4'h3, r);
        rc(ad(0), 32'h3000, `CMX_RESP_OKAY);
        for (int i = 0; i < 4; i++)
        begin
            // Supply codes assume setup buffers already on
            v = {1'b1, 1'b0, 2'(i), 2'b00, pc[i], nc[i]};
            wr(ad(i), v, 4'h3, r);
            rc(ad(i), {16'h0, v}, `CMX_RESP_OKAY);
        end
        repeat (3) @(posedge aclk);
        chk({act, setup}, 12'hFE4);
        chk(pos, {pc[3], pc[2], pc[1], pc[0]});
        chk(neg, {nc[3], nc[2], nc[1], nc[0]});
        // Low byte only; keeps both selectors on documented codes
        wr(ad(3), 16'h00A4, 4'h1, r);
        rc(ad(3), {16'h0, (v & 16'hFF00) | 16'h00A4}, `CMX_RESP_OKAY);
        $display("layout test done");
    endtask

    task automatic t_bad();
        logic [1:0] r;
        wr(10'h050, 16'h8000, 4'h3, r);
        chk(r, `CMX_RESP_SLVERR);
        rc(10'h03C, 32'h0, `CMX_RESP_SLVERR);
        chk(act, 4'hF);
        $display("unmapped test done");
    endtask

    task automatic t_seq();
        logic [1:0] r;
        int         h1;
        int         h3;
        logic [1:0] prv;
        h1 = 0;
        h3 = 0;
        prv = 2'd0;
        wr(ad(0), 16'h0001, 4'h3, r);
        wr(ad(2), 16'h0001, 4'h3, r);
        repeat (8) @(posedge aclk);
        repeat (24)
        begin
            @(posedge aclk);
            chk({cval, cch == 2'd1 || cch == 2'd3}, 2'b11);
            // Field outputs trail the channel number by one cycle
            if (prv != 2'd0)
                chk({csu, cps, cns, cpr, cnr}, (prv == 2'd1) ? 20'h63424 : 20'hEA481);
            prv = cch;
            h1 += int'(cch == 2'd1);
            h3 += int'(cch == 2'd3);
        end
        chk(h1 > 0 && h3 > 0, 1);
        wr(ad(1), 16'h0001, 4'h3, r);
        wr(ad(3), 16'h0001, 4'h3, r);
        repeat (6) @(posedge aclk);
        chk({cval, act}, 5'h00);
        $display("sequence test done");
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_layout();
        t_bad();
        t_seq();
        summarize();
    end
endmodule
`default_nettype wire
